// >>> dbc_pkg.sv
// Shared constants for the dual-band stereo compressor
package dbc_pkg;
  // Coefficient memory addresses
  localparam logic [7:0] MEM_BASE = 8'h40;
  localparam logic [7:0] BAND_ADDR = 8'h54;
  localparam logic [7:0] OFS_ADDR = 8'h68;
  localparam logic [7:0] DAW_ADDR = 8'h71;
  localparam logic [7:0] CRC_EXP_ADDR = 8'h72;
  localparam logic [7:0] CRC_CMP_ADDR = 8'h73;
  localparam logic [7:0] RANGE_ADDR = 8'h74;
  // Word indices inside the memory array
  localparam int MEM_WORDS = int'(RANGE_ADDR - MEM_BASE) + 1;
  localparam int BAND_IDX = int'(BAND_ADDR - MEM_BASE);
  localparam int OFS_IDX = int'(OFS_ADDR - MEM_BASE);
  localparam int DAW_IDX = int'(DAW_ADDR - MEM_BASE);
  localparam int CRC_EXP_IDX = int'(CRC_EXP_ADDR - MEM_BASE);
  localparam int CRC_CMP_IDX = int'(CRC_CMP_ADDR - MEM_BASE);
  localparam int RANGE_IDX = int'(RANGE_ADDR - MEM_BASE);
  // Splitter section layout: B1/2, B2, -A1/2, -A2, B0/2
  localparam int BQ_SETS = 4;
  localparam int BQ_STRIDE = 5;
  localparam int BQ_B1H = 0;
  localparam int BQ_B2 = 1;
  localparam int BQ_NA1H = 2;
  localparam int BQ_NA2 = 3;
  localparam int BQ_B0H = 4;
  // Per-band layout: release, attack, limiter, ratio, compressor
  localparam int BAND_STRIDE = 5;
  localparam int F_RR = 0;
  localparam int F_AR = 1;
  localparam int F_LT = 2;
  localparam int F_CR = 3;
  localparam int F_CT = 4;
  // Reset values
  localparam logic [23:0] RATE_RST = 24'h200000;
  localparam logic [23:0] B0H_RST = 24'h100000;
  localparam logic [23:0] RANGE_RST = 24'h0000aa;
  // Splitter coefficient range codes
  localparam logic [1:0] RANGE_1 = 2'h0;
  localparam logic [1:0] RANGE_2 = 2'h1;
  localparam logic [1:0] RANGE_4 = 2'h2;
  localparam int COEF_FRAC = 23;
  // Field positions of parameter words
  localparam int QDB_LSB = 15;
  localparam int RATE_LSB = 9;
  localparam int RATE_MSB = 21;
  localparam int CR_LSB = 17;
  localparam int DAW_FRAC = 25;
  localparam int DAW_MSB = 16;
  localparam int ATT_FRAC = 6;
  // Level and gain arithmetic
  localparam int QDB_PER_OCT = 24;
  localparam int GAIN_ONE = 256;
  localparam int GAIN_SLOPE = 11;
  localparam int PEAK_DECAY = 10;
  localparam int RMS_AVG = 8;
  // Ratio 1:R encoded as (1 - 1/R) * 256, index 15 first
  localparam logic [15:0][7:0] RATIO_K = {
    8'hf0, 8'he0, 8'hdb, 8'hd5, 8'hd1, 8'hcd, 8'hc7, 8'hc0,
    8'hb7, 8'hab, 8'h9a, 8'h80, 8'h6e, 8'h55, 8'h33, 8'h00};
  // Processing rate and attenuator step period
  localparam int SAMPLE_RATE_HZ = 96000;
  localparam int SAMPLES_PER_MS = SAMPLE_RATE_HZ / 1000;
endpackage

// >>> dbc_biquad.sv
// Second-order IIR section with selectable coefficient range
`timescale 1ns/100ps
`default_nettype none
module dbc_biquad (
  // Clock and reset
  input wire logic sys_clk_i,
  input wire logic rst_i,
  // Coefficients, words marked h hold half the value
  input wire logic [23:0] b0h_i,
  input wire logic [23:0] b1h_i,
  input wire logic [23:0] b2_i,
  input wire logic [23:0] na1h_i,
  input wire logic [23:0] na2_i,
  input wire logic [1:0] range_i,
  // Samples
  input wire logic x_vld_i,
  input wire logic [23:0] x_i,
  output logic y_vld_o,
  output logic [23:0] y_o
);
  typedef struct packed {
    logic [23:0] x1;
    logic [23:0] x2;
    logic [23:0] y1;
    logic [23:0] y2;
    logic vld;
  } bq_s;

  bq_s st_ff;
  bq_s nxt_st;
  logic signed [50:0] acc;
  logic signed [50:0] sc;
  logic [4:0] sh;

  function automatic logic signed [50:0] mul(input logic [23:0] a, input logic [23:0] b);
    return 51'($signed(a) * $signed(b));
  endfunction

  always_comb
  begin
    nxt_st = st_ff;
    nxt_st.vld = x_vld_i;
    // Reserved code falls back to the narrowest range
    case (range_i)
      dbc_pkg::RANGE_2: sh = 5'(dbc_pkg::COEF_FRAC - 1);
      dbc_pkg::RANGE_4: sh = 5'(dbc_pkg::COEF_FRAC - 2);
      default: sh = 5'(dbc_pkg::COEF_FRAC);
    endcase
    acc = ((mul(b0h_i, x_i) + mul(b1h_i, st_ff.x1) + mul(na1h_i, st_ff.y1)) <<< 1)
          + mul(b2_i, st_ff.x2) + mul(na2_i, st_ff.y2);
    sc = acc >>> sh;
    if (x_vld_i)
    begin
      nxt_st.x1 = x_i;
      nxt_st.x2 = st_ff.x1;
      nxt_st.y2 = st_ff.y1;
      if (sc > 51'sh7fffff)
        nxt_st.y1 = 24'h7fffff;
      else if (sc < -51'sh800000)
        nxt_st.y1 = 24'h800000;
      else
        nxt_st.y1 = sc[23:0];
    end
  end

  always_ff @(posedge sys_clk_i or posedge rst_i)
  begin
    if (rst_i)
      st_ff <= '0;
    else
      st_ff <= nxt_st;
  end

  assign y_o = st_ff.y1;
  assign y_vld_o = st_ff.vld;
endmodule // dbc_biquad
`default_nettype wire

// >>> dual_band_compressor.sv
// Stereo dual-band compressor: splitter, level meters, mappers, attenuators
// Function
// - Each of two channels is split, metered, mapped and attenuated on its own.
// - Splitter settings shared by channels; meter, mapper, attenuator settings per band.
// - Each band filter is two cascaded biquads, up to fourth order.
// - A control enables or disables recombining both bands per channel.
// - Two-bit range code: 00 [-1,1), 01 [-2,2), 10 [-4,4), 11 reserved.
// - After reset the splitter uses the [-4,4) range.
// - Peak and RMS are measured in dB; choice made from mapper setup and signal.
// - Level below compressor threshold leaves the band unattenuated.
// - Level between thresholds compresses the band by the programmed ratio.
// - Level above limiter threshold is limited to that threshold.
// - Compressor threshold -48 to 0 dB in 0.25 dB steps per band.
// - Limiter threshold -24 to +12 dB in 0.25 dB steps per band.
// - Ratio index 0 to 15 decodes 1:1 up to 1:16.
// - Ratio 1:1 or compressor threshold above limiter gives a pure limiter.
// - Attack lowers gain toward target at 0 to 16 dB/ms, 0.25 steps.
// - Release below limiter threshold restores gain at 0.0078 to 1 dB/ms.
// - Attenuator output level is fed back and compared with mapper target.
// - Dynamic attack weight times level error lengthens attack time.
// - One dynamic attack weight, 0 to 1 ms/dB, serves all four bands.
// - Per-band offset 0 to +48 dB sits ahead of the attenuator.
// - Volume sits after the attenuator; host should use offset for loudness.
// - Config bits give data-flow control and a coefficient checksum enable.
`timescale 1ns/100ps
`default_nettype none
module dual_band_compressor (
  // Clock and reset
  input wire logic sys_clk_i,
  input wire logic rst_i,
  // Configuration levels
  input wire logic dbc_en_i,
  input wire logic recomb_en_i,
  input wire logic cks_en_i,
  // Coefficient memory port
  input wire logic coef_wr_i,
  input wire logic coef_rd_i,
  input wire logic [7:0] coef_addr_i,
  input wire logic [23:0] coef_wdata_i,
  output logic [23:0] coef_rdata_o,
  output logic cks_fault_o,
  // Sample stream in
  input wire logic smp_vld_i,
  input wire logic [23:0] smp_ch0_i,
  input wire logic [23:0] smp_ch1_i,
  // Sample stream out
  output logic out_vld_o,
  output logic [23:0] out_ch0_o,
  output logic [23:0] out_ch1_o,
  output logic [23:0] out_ch0_hi_o,
  output logic [23:0] out_ch1_hi_o
);
  localparam int NW = dbc_pkg::MEM_WORDS;
  localparam int NB = 4;

  typedef struct packed {
    logic [NW-1:0][23:0] mem;
    logic [NB-1:0][23:0] peak;
    logic [NB-1:0][23:0] msq;
    logic [NB-1:0][17:0] att;
    logic [6:0] tick_cnt;
    logic [23:0] rdata;
    logic fault;
    logic vld;
    logic [1:0][23:0] lo;
    logic [1:0][23:0] hi;
  } st_s;

  st_s st_ff;
  st_s nxt_st;

  logic [1:0][3:0][23:0] bq_x;
  logic [1:0][3:0] bq_xv;
  logic [1:0][3:0][23:0] bq_y;
  logic [1:0][3:0] bq_v;
  logic [3:0][4:0][23:0] coef;
  logic [NB-1:0][23:0] band_smp;
  logic [NB-1:0][23:0] band_out;
  logic [NB-1:0][23:0] nxt_pk;
  logic [NB-1:0][23:0] nxt_ms;
  logic [NB-1:0][17:0] nxt_att;
  logic band_vld;
  logic [7:0] widx;
  logic in_map;
  logic [23:0] cks;
  logic tick;

  function automatic st_s rst_val();
    st_s s;
    s = '0;
    for (int i = 0; i < dbc_pkg::BQ_SETS; i++)
    begin
      s.mem[i * dbc_pkg::BQ_STRIDE + dbc_pkg::BQ_B0H] = dbc_pkg::B0H_RST;
      s.mem[dbc_pkg::BAND_IDX + i * dbc_pkg::BAND_STRIDE + dbc_pkg::F_RR] = dbc_pkg::RATE_RST;
      s.mem[dbc_pkg::BAND_IDX + i * dbc_pkg::BAND_STRIDE + dbc_pkg::F_AR] = dbc_pkg::RATE_RST;
    end
    s.mem[dbc_pkg::RANGE_IDX] = dbc_pkg::RANGE_RST;
    return s;
  endfunction

  // Coarse log2 in 0.25 dB units: 6 dB per octave, linear inside the octave
  function automatic logic signed [10:0] qdb(input logic [23:0] v);
    logic signed [10:0] r;
    r = -11'sh230;
    for (int i = 3; i < 24; i++)
      if (v[i])
        r = 11'((i - 23) * dbc_pkg::QDB_PER_OCT + 3 * int'(v[i-1 -: 3]));
    return r;
  endfunction

  function automatic logic [23:0] sat24(input logic signed [63:0] p);
    if (p > 64'sh7fffff)
      return 24'h7fffff;
    if (p < -64'sh800000)
      return 24'h800000;
    return p[23:0];
  endfunction

  // Gain in 0.25 dB units as shift plus a linear mantissa
  function automatic logic [23:0] gain(input logic [23:0] x, input logic signed [13:0] g);
    int sh;
    int r;
    logic signed [63:0] p;
    sh = int'(g) / dbc_pkg::QDB_PER_OCT;
    r = int'(g) - sh * dbc_pkg::QDB_PER_OCT;
    if (r < 0)
    begin
      r = r + dbc_pkg::QDB_PER_OCT;
      sh = sh - 1;
    end
    p = 64'($signed(x)) * 64'(dbc_pkg::GAIN_ONE + r * dbc_pkg::GAIN_SLOPE);
    p = p >>> 8;
    if (sh >= 0)
      p = p <<< sh;
    else if (sh > -63)
      p = p >>> (-sh);
    else
      p = 64'sh0;
    return sat24(p);
  endfunction

  // Splitter coefficients; a failed checksum falls back to the reset values, pass-through only in the [-4,4) range
  for (genvar q = 0; q < dbc_pkg::BQ_SETS; q++)
  begin : g_coef
    for (genvar f = 0; f < dbc_pkg::BQ_STRIDE; f++)
    begin : g_word
      assign coef[q][f] = !st_ff.fault ? st_ff.mem[q * dbc_pkg::BQ_STRIDE + f]
                          : (f == dbc_pkg::BQ_B0H ? dbc_pkg::B0H_RST : 24'h0);
    end
  end

  // Set q: band q/2, section q%2; coefficients shared by both channels
  for (genvar c = 0; c < 2; c++)
  begin : g_ch
    for (genvar q = 0; q < dbc_pkg::BQ_SETS; q++)
    begin : g_sec
      if (q % 2 == 0)
      begin : g_first
        assign bq_x[c][q] = (c == 0) ? smp_ch0_i : smp_ch1_i;
        assign bq_xv[c][q] = smp_vld_i;
      end
      else
      begin : g_next
        assign bq_x[c][q] = bq_y[c][q-1];
        assign bq_xv[c][q] = bq_v[c][q-1];
      end
      dbc_biquad u_bq (
        .sys_clk_i(sys_clk_i),
        .rst_i(rst_i),
        .b0h_i(coef[q][dbc_pkg::BQ_B0H]),
        .b1h_i(coef[q][dbc_pkg::BQ_B1H]),
        .b2_i(coef[q][dbc_pkg::BQ_B2]),
        .na1h_i(coef[q][dbc_pkg::BQ_NA1H]),
        .na2_i(coef[q][dbc_pkg::BQ_NA2]),
        .range_i(st_ff.mem[dbc_pkg::RANGE_IDX][q*2+1 -: 2]),
        .x_vld_i(bq_xv[c][q]),
        .x_i(bq_x[c][q]),
        .y_vld_o(bq_v[c][q]),
        .y_o(bq_y[c][q])
      );
    end
    assign band_smp[c*2] = bq_y[c][1];
    assign band_smp[c*2+1] = bq_y[c][3];
  end

  assign band_vld = bq_v[0][3];

  // Band k = channel * 2 + band, each with its own parameter words
  for (genvar k = 0; k < NB; k++)
  begin : g_band
    localparam int P = dbc_pkg::BAND_IDX + k * dbc_pkg::BAND_STRIDE;
    logic [23:0] smp;
    logic [23:0] mag;
    logic [47:0] sq;
    logic signed [24:0] dms;
    logic signed [10:0] lt;
    logic signed [10:0] ct;
    logic signed [10:0] ofs;
    logic signed [10:0] pk_l;
    logic signed [10:0] lvl;
    logic signed [10:0] inl;
    logic signed [10:0] cl;
    logic [3:0] cr;
    logic pure_lim;
    logic [16:0] comp_att;
    logic [10:0] lim_att;
    logic signed [19:0] tgt;
    logic signed [19:0] out_l;
    logic signed [19:0] map_l;
    logic signed [19:0] diff;
    logic [17:0] up;
    logic [17:0] dn;
    logic [12:0] ar;
    logic [12:0] rr;
    logic [39:0] eff;
    logic signed [13:0] g;

    assign smp = band_smp[k];
    assign mag = !smp[23] ? smp : (smp == 24'h800000 ? 24'h7fffff : 24'(-$signed(smp)));
    assign sq = mag * mag;
    assign nxt_pk[k] = (mag > st_ff.peak[k]) ? mag
                       : st_ff.peak[k] - (st_ff.peak[k] >> dbc_pkg::PEAK_DECAY);
    assign dms = $signed({1'b0, sq[46:23]}) - $signed({1'b0, st_ff.msq[k]});
    assign nxt_ms[k] = 24'($signed({1'b0, st_ff.msq[k]}) + (dms >>> dbc_pkg::RMS_AVG));

    assign lt = 11'($signed(st_ff.mem[P + dbc_pkg::F_LT][23:dbc_pkg::QDB_LSB]));
    assign ct = 11'($signed(st_ff.mem[P + dbc_pkg::F_CT][23:dbc_pkg::QDB_LSB]));
    assign ofs = 11'($signed(st_ff.mem[dbc_pkg::OFS_IDX + k][23:dbc_pkg::QDB_LSB]));
    assign cr = st_ff.mem[P + dbc_pkg::F_CR][dbc_pkg::CR_LSB+3 -: 4];
    assign pure_lim = (cr == 4'h0) || (ct > lt);

    // Peak in pure-limiter mode or with the peak above the limit, otherwise the smoother RMS
    assign pk_l = qdb(st_ff.peak[k]);
    assign lvl = (pure_lim || pk_l > lt) ? pk_l : (qdb(st_ff.msq[k]) >>> 1);
    assign inl = lvl + ofs;

    assign cl = (inl < lt) ? inl : lt;
    assign comp_att = (!pure_lim && cl > ct)
                      ? 17'((19'(cl - ct) * 19'(dbc_pkg::RATIO_K[cr])) >> 8) : 17'h0;
    assign lim_att = (inl > lt) ? 11'(inl - lt) : 11'h0;
    assign tgt = (20'(comp_att) + 20'(lim_att)) <<< dbc_pkg::ATT_FRAC;

    // Level error: attenuated output level against the mapper level
    assign out_l = (20'(inl) <<< dbc_pkg::ATT_FRAC) - $signed({2'h0, st_ff.att[k]});
    assign map_l = (20'(inl) <<< dbc_pkg::ATT_FRAC) - tgt;
    assign diff = out_l - map_l;
    assign up = 18'(diff);
    assign dn = 18'(-diff);

    assign ar = st_ff.mem[P + dbc_pkg::F_AR][dbc_pkg::RATE_MSB:dbc_pkg::RATE_LSB];
    assign rr = st_ff.mem[P + dbc_pkg::F_RR][dbc_pkg::RATE_MSB:dbc_pkg::RATE_LSB];
    // Attack time d/AR + d*W reduces to an effective rate AR / (1 + AR*W)
    assign eff = (40'(ar) << dbc_pkg::DAW_FRAC)
                 / ((40'h1 << dbc_pkg::DAW_FRAC)
                 + 40'(ar) * 40'(st_ff.mem[dbc_pkg::DAW_IDX][dbc_pkg::DAW_MSB:0]));

    assign nxt_att[k] = !dbc_en_i ? 18'h0
      : (diff > 20'sh0) ? st_ff.att[k] + ((40'(up) < eff) ? up : 18'(eff))
      : (diff < 20'sh0 && inl <= lt) ? st_ff.att[k] - ((dn < 18'(rr)) ? dn : 18'(rr))
      : st_ff.att[k];

    // Offset and attenuation act on the band; volume follows downstream
    assign g = 14'(ofs) - $signed({2'h0, st_ff.att[k][17:dbc_pkg::ATT_FRAC]});
    assign band_out[k] = dbc_en_i ? gain(smp, g) : smp;
  end

  assign widx = coef_addr_i - dbc_pkg::MEM_BASE;
  assign in_map = (coef_addr_i >= dbc_pkg::MEM_BASE) && (coef_addr_i <= dbc_pkg::RANGE_ADDR);
  assign tick = (st_ff.tick_cnt == 7'(dbc_pkg::SAMPLES_PER_MS - 1));

  always_comb
  begin
    nxt_st = st_ff;
    // Checksum runs over the splitter words only
    cks = 24'h0;
    for (int i = 0; i < dbc_pkg::BQ_SETS * dbc_pkg::BQ_STRIDE; i++)
      cks = cks + st_ff.mem[i];
    nxt_st.mem[dbc_pkg::CRC_CMP_IDX] = cks;
    nxt_st.fault = cks_en_i && (cks != st_ff.mem[dbc_pkg::CRC_EXP_IDX]);
    // The computed checksum word is read-only
    if (coef_wr_i && in_map && coef_addr_i != dbc_pkg::CRC_CMP_ADDR)
      nxt_st.mem[widx] = coef_wdata_i;
    if (coef_rd_i)
      nxt_st.rdata = in_map ? st_ff.mem[widx] : 24'h0;
    nxt_st.vld = band_vld;
    if (band_vld)
    begin
      nxt_st.peak = nxt_pk;
      nxt_st.msq = nxt_ms;
      // Gain moves once per millisecond of samples so rates stay in dB/ms
      nxt_st.tick_cnt = tick ? 7'h0 : st_ff.tick_cnt + 7'h1;
      if (tick || !dbc_en_i)
        nxt_st.att = nxt_att;
      for (int c = 0; c < 2; c++)
      begin
        nxt_st.hi[c] = band_out[c*2+1];
        if (recomb_en_i)
          nxt_st.lo[c] = sat24(64'($signed(band_out[c*2])) + 64'($signed(band_out[c*2+1])));
        else
          nxt_st.lo[c] = band_out[c*2];
      end
    end
  end

  always_ff @(posedge sys_clk_i or posedge rst_i)
  begin
    if (rst_i)
      st_ff <= rst_val();
    else
      st_ff <= nxt_st;
  end

  assign coef_rdata_o = st_ff.rdata;
  assign cks_fault_o = st_ff.fault;
  assign out_vld_o = st_ff.vld;
  assign out_ch0_o = st_ff.lo[0];
  assign out_ch1_o = st_ff.lo[1];
  assign out_ch0_hi_o = st_ff.hi[0];
  assign out_ch1_hi_o = st_ff.hi[1];
endmodule // dual_band_compressor
`default_nettype wire

// >>> dbc_properties.sv
// Port-level checks for the dual-band stereo compressor
`timescale 1ns/100ps
`default_nettype none
module dbc_properties (
  // Clock and reset
  input wire logic sys_clk_i,
  input wire logic rst_i,
  // Configuration and coefficient port
  input wire logic dbc_en_i,
  input wire logic recomb_en_i,
  input wire logic cks_en_i,
  input wire logic coef_wr_i,
  input wire logic coef_rd_i,
  input wire logic [7:0] coef_addr_i,
  input wire logic [23:0] coef_wdata_i,
  input wire logic [23:0] coef_rdata_o,
  input wire logic cks_fault_o,
  // Sample streams
  input wire logic smp_vld_i,
  input wire logic [23:0] smp_ch0_i,
  input wire logic [23:0] smp_ch1_i,
  input wire logic out_vld_o,
  input wire logic [23:0] out_ch0_o,
  input wire logic [23:0] out_ch1_o,
  input wire logic [23:0] out_ch0_hi_o,
  input wire logic [23:0] out_ch1_hi_o
);
  default clocking cb @(posedge sys_clk_i); endclocking
  default disable iff (rst_i);
  logic plain_word;
  // Full-width words only; packed fields may be masked on storage
  assign plain_word = ((coef_addr_i >= 8'h40) && (coef_addr_i <= 8'h6b)) || (coef_addr_i == 8'h72);
  sequence s_write;
    coef_wr_i && plain_word;
  endsequence
  sequence s_read_same;
    coef_rd_i && !coef_wr_i && $stable(coef_addr_i);
  endsequence
  sequence s_quiet;
    (!coef_wr_i && $stable(cks_en_i)) [*4];
  endsequence
  a_out_latency: assert property (smp_vld_i |-> ##3 out_vld_o)
    else $error("output pair missing three cycles after an input pair");
  a_no_spurious: assert property (!smp_vld_i |-> ##3 !out_vld_o)
    else $error("output pair without an input pair");
  a_out_hold: assert property (!out_vld_o |-> $stable({out_ch0_o, out_ch1_o, out_ch0_hi_o, out_ch1_hi_o}))
    else $error("output samples changed without a valid pulse");
  a_rdata_hold: assert property (!coef_rd_i |=> $stable(coef_rdata_o))
    else $error("read data changed without a read");
  a_unmapped_zero: assert property (coef_rd_i && (coef_addr_i < 8'h40 || coef_addr_i > 8'h74) |=>
    coef_rdata_o == 24'h000000) else $error("unmapped read returned nonzero data");
  a_write_echo: assert property (s_write ##1 s_read_same |=> coef_rdata_o == $past(coef_wdata_i, 2))
    else $error("read after write returned other data");
  a_fault_off: assert property (!cks_en_i |=> !cks_fault_o)
    else $error("checksum fault raised while checking is off");
  a_fault_steady: assert property (s_quiet |=> $stable(cks_fault_o))
    else $error("checksum fault moved without a write or enable change");
endmodule // dbc_properties
bind dual_band_compressor dbc_properties u_dbc_properties (.sys_clk_i(sys_clk_i), .rst_i(rst_i),
  .dbc_en_i(dbc_en_i), .recomb_en_i(recomb_en_i), .cks_en_i(cks_en_i), .coef_wr_i(coef_wr_i),
  .coef_rd_i(coef_rd_i), .coef_addr_i(coef_addr_i), .coef_wdata_i(coef_wdata_i), .coef_rdata_o(coef_rdata_o),
  .cks_fault_o(cks_fault_o), .smp_vld_i(smp_vld_i), .smp_ch0_i(smp_ch0_i), .smp_ch1_i(smp_ch1_i),
  .out_vld_o(out_vld_o), .out_ch0_o(out_ch0_o), .out_ch1_o(out_ch1_o), .out_ch0_hi_o(out_ch0_hi_o),
  .out_ch1_hi_o(out_ch1_hi_o));
`default_nettype wire

// >>> dbc_sample_src.sv
// Upstream processing stage model: a sample pair every second cycle
`timescale 1ns/100ps
`default_nettype none
module dbc_sample_src (
  // Clock and reset
  input wire logic sys_clk_i,
  input wire logic rst_i,
  // Bench control
  input wire logic run_i,
  input wire logic [23:0] lvl_ch0_i,
  input wire logic [23:0] lvl_ch1_i,
  // Stream towards the block
  output logic smp_vld_o,
  output logic [23:0] smp_ch0_o,
  output logic [23:0] smp_ch1_o
);
  // Between pairs the data lines carry the inverse, so unqualified data is never mistaken for a sample
  always_ff @(posedge sys_clk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      smp_vld_o <= 1'b0;
      smp_ch0_o <= 24'h000000;
      smp_ch1_o <= 24'h000000;
    end
    else
    begin
      smp_vld_o <= run_i && !smp_vld_o;
      smp_ch0_o <= (run_i && !smp_vld_o) ? lvl_ch0_i : ~lvl_ch0_i;
      smp_ch1_o <= (run_i && !smp_vld_o) ? lvl_ch1_i : ~lvl_ch1_i;
    end
  end
endmodule // dbc_sample_src
`default_nettype wire

// >>> tb_dual_band_compressor.sv
// Self-checking bench for the dual-band stereo compressor
`timescale 1ns/100ps
`default_nettype none
`define CHK(nm, e, g) begin cmp_count++; if ((g) !== (e)) begin n_fail++; $display("BAD %s exp %h got %h", nm, e, g); end end
module tb_dual_band_compressor;
  logic sys_clk_i = 1'b0;
  logic rst_i = 1'b1;
  logic dbc_en_i = 1'b0;
  logic recomb_en_i = 1'b0;
  logic cks_en_i = 1'b0;
  logic coef_wr_i = 1'b0;
  logic coef_rd_i = 1'b0;
  logic [7:0] coef_addr_i = 8'h00;
  logic [23:0] coef_wdata_i = 24'h000000;
  logic [23:0] coef_rdata_o;
  logic cks_fault_o;
  logic run = 1'b0;
  logic [23:0] lvl0 = 24'h000000;
  logic [23:0] lvl1 = 24'h000000;
  logic smp_vld_i;
  logic [23:0] smp_ch0_i;
  logic [23:0] smp_ch1_i;
  logic out_vld_o;
  logic [23:0] out_ch0_o;
  logic [23:0] out_ch1_o;
  logic [23:0] out_ch0_hi_o;
  logic [23:0] out_ch1_hi_o;
  int n_fail = 0;
  int cmp_count = 0;
  dbc_sample_src u_dbc_sample_src (.sys_clk_i(sys_clk_i), .rst_i(rst_i), .run_i(run), .lvl_ch0_i(lvl0),
    .lvl_ch1_i(lvl1), .smp_vld_o(smp_vld_i), .smp_ch0_o(smp_ch0_i), .smp_ch1_o(smp_ch1_i));
  dual_band_compressor u_dual_band_compressor (.sys_clk_i(sys_clk_i), .rst_i(rst_i), .dbc_en_i(dbc_en_i),
    .recomb_en_i(recomb_en_i), .cks_en_i(cks_en_i), .coef_wr_i(coef_wr_i), .coef_rd_i(coef_rd_i),
    .coef_addr_i(coef_addr_i), .coef_wdata_i(coef_wdata_i), .coef_rdata_o(coef_rdata_o),
    .cks_fault_o(cks_fault_o), .smp_vld_i(smp_vld_i), .smp_ch0_i(smp_ch0_i), .smp_ch1_i(smp_ch1_i),
    .out_vld_o(out_vld_o), .out_ch0_o(out_ch0_o), .out_ch1_o(out_ch1_o), .out_ch0_hi_o(out_ch0_hi_o),
    .out_ch1_hi_o(out_ch1_hi_o));
  initial
  begin
    forever #5 sys_clk_i = ~sys_clk_i;
  end
  task automatic stop_test();
    $display("comparisons %0d mismatches %0d", cmp_count, n_fail);
    if (n_fail == 0 && cmp_count > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask
  task automatic do_reset();
    @(posedge sys_clk_i);
    rst_i <= 1'b1;
    repeat (12) @(posedge sys_clk_i);
    rst_i <= 1'b0;
  endtask
  task automatic idle(input int n);
    repeat (n) @(posedge sys_clk_i);
    @(negedge sys_clk_i);
  endtask
  task automatic wr(input logic [7:0] a, input logic [23:0] d);
    @(posedge sys_clk_i);
    coef_wr_i <= 1'b1;
    coef_addr_i <= a;
    coef_wdata_i <= d;
    @(posedge sys_clk_i);
    coef_wr_i <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, input logic [23:0] e);
    @(posedge sys_clk_i);
    coef_rd_i <= 1'b1;
    coef_addr_i <= a;
    @(posedge sys_clk_i);
    coef_rd_i <= 1'b0;
    @(negedge sys_clk_i);
    `CHK("rdata", e, coef_rdata_o)
  endtask
  // Read issued in the cycle right after the write, the tightest legal spacing
  task automatic wr_rd(input logic [7:0] a, input logic [23:0] d);
    @(posedge sys_clk_i);
    coef_wr_i <= 1'b1;
    coef_addr_i <= a;
    coef_wdata_i <= d;
    @(posedge sys_clk_i);
    coef_wr_i <= 1'b0;
    coef_rd_i <= 1'b1;
    @(posedge sys_clk_i);
    coef_rd_i <= 1'b0;
    @(negedge sys_clk_i);
    `CHK("echo", d, coef_rdata_o)
  endtask
  task automatic stream(input logic [23:0] l0, input logic [23:0] l1, input int n);
    int seen;
    seen = 0;
    @(posedge sys_clk_i);
    lvl0 <= l0;
    lvl1 <= l1;
    run <= 1'b1;
    repeat (n)
    begin
      @(negedge sys_clk_i);
      if (out_vld_o === 1'b1)
        seen++;
    end
    @(posedge sys_clk_i);
    run <= 1'b0;
    idle(6);
    `CHK("flow", 1'b1, seen > 0)
  endtask
  task automatic t_regs();
    rd(8'h54, 24'h200000);
    rd(8'h55, 24'h200000);
    rd(8'h44, 24'h100000);
    rd(8'h74, 24'h0000aa);
    rd(8'h56, 24'h000000);
    rd(8'h75, 24'h000000);
    for (int i = 0; i < 16; i++)
    begin
      wr_rd(8'h57, 24'(i) << 17);
    end
    wr_rd(8'h57, 24'h000000);
    wr_rd(8'h58, 24'ha00000);
    wr_rd(8'h58, 24'h000000);
    wr_rd(8'h71, 24'h01ffff);
    wr_rd(8'h71, 24'h000000);
    $display("t_regs done");
  endtask
  task automatic t_bands();
    for (int r = 0; r < 2; r++)
    begin
      @(posedge sys_clk_i);
      recomb_en_i <= r[0];
      stream(24'h500000, 24'hb00000, 200);
      `CHK("sum0", r ? 24'h7fffff : 24'h500000, out_ch0_o)
      `CHK("sum1", r ? 24'h800000 : 24'hb00000, out_ch1_o)
      `CHK("hi0", 24'h500000, out_ch0_hi_o)
      `CHK("hi1", 24'hb00000, out_ch1_hi_o)
    end
    @(posedge sys_clk_i);
    recomb_en_i <= 1'b0;
    $display("t_bands done");
  endtask
  task automatic t_range();
    logic [23:0] exp_lo [4] = '{24'h080000, 24'h100000, 24'h200000, 24'h080000};
    for (int c = 0; c < 4; c++)
    begin
      wr(8'h74, 24'h0000a8 | 24'(c));
      stream(24'h200000, 24'h200000, 100);
      `CHK("lo_range", exp_lo[c], out_ch0_o)
      `CHK("ch1_range", exp_lo[c], out_ch1_o)
      `CHK("hi_range", 24'h200000, out_ch0_hi_o)
    end
    wr(8'h74, 24'h0000aa);
    $display("t_range done");
  endtask
  task automatic t_cks();
    @(posedge sys_clk_i);
    cks_en_i <= 1'b1;
    idle(3);
    `CHK("fault_dflt", 1'b1, cks_fault_o)
    rd(8'h73, 24'h400000);
    wr(8'h72, 24'h400000);
    wr(8'h73, 24'h123456);
    idle(3);
    `CHK("fault_ok", 1'b0, cks_fault_o)
    rd(8'h73, 24'h400000);
    wr(8'h44, 24'h080000);
    stream(24'h200000, 24'h200000, 100);
    `CHK("fault_bad", 1'b1, cks_fault_o)
    `CHK("fault_pass", 24'h200000, out_ch0_o)
    wr(8'h44, 24'h100000);
    @(posedge sys_clk_i);
    cks_en_i <= 1'b0;
    $display("t_cks done");
  endtask
  task automatic t_dyn();
    @(posedge sys_clk_i);
    dbc_en_i <= 1'b1;
    // Loudness is raised through the band offset, ahead of the attenuator
    wr(8'h68, 24'h0c0000);
    stream(24'h100000, 24'h040000, 2000);
    `CHK("offset", 1'b1, out_ch0_o > 24'h1c0000 && out_ch0_o < 24'h240000)
    `CHK("quiet", 24'h040000, out_ch1_o)
    wr(8'h68, 24'h000000);
    wr(8'h56, 24'he80000);
    stream(24'h7fffff, 24'h040000, 3000);
    `CHK("limit", 1'b1, out_ch0_o > 24'h000000 && out_ch0_o < 24'h300000)
    `CHK("indep", 24'h040000, out_ch1_o)
    // Peak meter needs about 1300 samples to fall below the limit, plus one gain step
    stream(24'h040000, 24'h040000, 6000);
    `CHK("release", 24'h040000, out_ch0_o)
    wr(8'h56, 24'h000000);
    @(posedge sys_clk_i);
    dbc_en_i <= 1'b0;
    $display("t_dyn done");
  endtask
  task automatic t_rerst();
    wr(8'h74, 24'h000055);
    do_reset();
    rd(8'h74, 24'h0000aa);
    $display("t_rerst done");
  endtask
  initial
  begin
    do_reset();
    t_regs();
    t_bands();
    t_range();
    t_cks();
    t_dyn();
    t_rerst();
    stop_test();
  end
endmodule // tb_dual_band_compressor
`default_nettype wire
